//--- op_timing_params.svh
`ifndef OP_TIMING_PARAMS_SVH
`define OP_TIMING_PARAMS_SVH

// Field widths of a cost triple and of the shift count
`define CLK_W 10
`define RW_W 4
`define CNT_W 6

// Register shift and rotate base clocks and clocks per bit
`define SHIFT_BASE_SHORT 6
`define SHIFT_BASE_LONG 8
`define SHIFT_PER_BIT 2

// Extra clocks of the predecrement forms in loop mode
`define PREDEC_EXTRA 2

// Answer latency in clock periods
`define RESP_LATENCY 1

`endif

//--- op_timing_pkg.sv
package op_timing_pkg;
`include "op_timing_params.svh"

    typedef enum logic [3:0] {
        clear_operand, decimal_negate, twos_complement_op, complement_with_extend,
        ones_complement, test_operand, cond_set, locked_test_set,
        arith_shift, logical_shift, rotate_plain, rotate_through_extend,
        bit_flip, bit_clear, bit_set_op, bit_test
    } op_class_t;

    typedef enum logic [1:0] {sz_byte, sz_word, sz_long} op_size_t;

    typedef enum logic [3:0] {
        data_reg_direct, addr_reg_direct, ea_ind, ea_postinc, ea_predec,
        ea_disp16, ea_indexed, ea_abs_w, ea_abs_l
    } ea_mode_t;

    typedef enum logic [1:0] {loop_continue, loop_cc_true, loop_expired} loop_out_t;

    typedef struct packed {
        logic [`CLK_W-1:0] clocks;
        logic [`RW_W-1:0] reads;
        logic [`RW_W-1:0] writes;
    } cost_t;

    typedef struct packed {
        op_class_t cls;
        op_size_t size;
        ea_mode_t mode;
        logic static_bit;
        logic index_long;
        logic looped;
        loop_out_t outcome;
        logic [`CNT_W-1:0] count;
        cost_t ea_cost;
        cost_t ea_nf_cost;
    } op_req_t;

endpackage

//--- op_timing.sv
`timescale 1ns/1ps
`include "op_timing_params.svh"
module op_timing
    import op_timing_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic req_valid,
    input wire op_req_t req,
    output logic resp_valid_r,
    output cost_t resp_cost_r,
    output logic resp_illegal_r
);

    function automatic cost_t mk(input int c, input int r, input int w);
        cost_t x;
        x.clocks = `CLK_W'(c);
        x.reads = `RW_W'(r);
        x.writes = `RW_W'(w);
        return x;
    endfunction

    function automatic cost_t add(input cost_t a, input cost_t b);
        cost_t x;
        x.clocks = `CLK_W'(a.clocks + b.clocks);
        x.reads = `RW_W'(a.reads + b.reads);
        x.writes = `RW_W'(a.writes + b.writes);
        return x;
    endfunction

    function automatic cost_t pick3(input loop_out_t o, input cost_t a, input cost_t b,
                                    input cost_t c);
        if (o == loop_continue) begin
            return a;
        end
        return (o == loop_cc_true) ? b : c;
    endfunction

    // Loop mode costs for (An) and (An)+, predecrement adjusted
    function automatic cost_t loop_cost(input op_class_t cls, input logic lng,
                                        input loop_out_t o, input logic pre);
        cost_t x;
        x = mk(0, 0, 0);
        unique case (cls)
            clear_operand: x = lng ? pick3(o, mk(14, 0, 2), mk(22, 2, 2), mk(20, 2, 2))
                                   : pick3(o, mk(10, 0, 1), mk(18, 2, 1), mk(16, 2, 1));
            decimal_negate: x = pick3(o, mk(18, 1, 1), mk(24, 3, 1), mk(22, 3, 1));
            twos_complement_op, complement_with_extend, ones_complement:
                x = lng ? pick3(o, mk(24, 2, 2), mk(30, 4, 2), mk(28, 4, 2))
                        : pick3(o, mk(16, 1, 1), mk(22, 3, 1), mk(20, 3, 1));
            test_operand: x = lng ? pick3(o, mk(18, 2, 0), mk(24, 4, 0), mk(20, 4, 0))
                                  : pick3(o, mk(12, 1, 0), mk(18, 3, 0), mk(16, 3, 0));
            default: x = pick3(o, mk(18, 1, 1), mk(24, 3, 1), mk(22, 3, 1));
        endcase
        if (pre) begin
            x.clocks = `CLK_W'(x.clocks + `PREDEC_EXTRA);
            if (cls == clear_operand && !lng && o == loop_cc_true) begin
                x.writes = '0;
            end
            if (!lng && o == loop_continue && (cls == twos_complement_op ||
                cls == complement_with_extend || cls == ones_complement)) begin
                x.reads = `RW_W'(2);
                x.writes = `RW_W'(2);
            end
        end
        return x;
    endfunction

    cost_t cost_nxt;
    logic illegal_nxt;
    logic is_mem;
    logic is_long;
    logic loop_mode_ok;

    assign is_mem = req.mode != data_reg_direct && req.mode != addr_reg_direct;
    assign is_long = req.size == sz_long;
    assign loop_mode_ok = req.mode == ea_ind || req.mode == ea_postinc ||
                          req.mode == ea_predec;

    // Cost lookup; index_long is never consulted
    always_comb begin
        cost_nxt = mk(0, 0, 0);
        illegal_nxt = req.mode == addr_reg_direct;
        if (req.looped) begin
            cost_nxt = loop_cost(req.cls, is_long, req.outcome, req.mode == ea_predec);
            if (!loop_mode_ok || req.cls > arith_shift && req.cls > rotate_through_extend ||
                req.cls == cond_set || req.cls == locked_test_set) begin
                illegal_nxt = 1'b1;
            end
            if (req.cls >= arith_shift && req.size != sz_word) begin
                illegal_nxt = 1'b1;
            end
            if (req.cls == decimal_negate && req.size != sz_byte) begin
                illegal_nxt = 1'b1;
            end
        end else begin
            unique case (req.cls)
                clear_operand: begin
                    if (!is_mem) begin
                        cost_nxt = is_long ? mk(6, 1, 0) : mk(4, 1, 0);
                    end else begin
                        unique case (req.mode)
                            ea_ind, ea_postinc: cost_nxt = mk(8, 1, 1);
                            ea_predec: cost_nxt = mk(10, 1, 1);
                            ea_disp16, ea_abs_w: cost_nxt = mk(12, 2, 1);
                            ea_indexed: cost_nxt = mk(16, 2, 1);
                            default: cost_nxt = mk(16, 3, 1);
                        endcase
                        if (is_long) begin
                            cost_nxt.clocks = `CLK_W'(cost_nxt.clocks + 4);
                            cost_nxt.writes = `RW_W'(2);
                        end
                    end
                end
                decimal_negate: begin
                    illegal_nxt = illegal_nxt || req.size != sz_byte;
                    cost_nxt = is_mem ? add(mk(8, 1, 1), req.ea_cost) : mk(6, 1, 0);
                end
                twos_complement_op, complement_with_extend, ones_complement: begin
                    if (is_mem) begin
                        cost_nxt = add(is_long ? mk(12, 1, 2) : mk(8, 1, 1), req.ea_cost);
                    end else begin
                        cost_nxt = is_long ? mk(6, 1, 0) : mk(4, 1, 0);
                    end
                end
                test_operand: cost_nxt = is_mem ? add(mk(4, 1, 0), req.ea_cost) : mk(4, 1, 0);
                cond_set, locked_test_set: begin
                    illegal_nxt = illegal_nxt || req.size != sz_byte;
                    if (!is_mem) begin
                        cost_nxt = mk(4, 1, 0);
                    end else begin
                        cost_nxt = add(req.cls == cond_set ? mk(8, 1, 1) : mk(14, 2, 1),
                                       req.ea_nf_cost);
                    end
                end
                arith_shift, logical_shift, rotate_plain, rotate_through_extend: begin
                    if (is_mem) begin
                        illegal_nxt = illegal_nxt || req.size != sz_word;
                        cost_nxt = add(mk(8, 1, 1), req.ea_cost);
                    end else begin
                        cost_nxt = mk((is_long ? `SHIFT_BASE_LONG : `SHIFT_BASE_SHORT) +
                                      `SHIFT_PER_BIT * int'(req.count), 1, 0);
                    end
                end
                default: begin
                    if (!is_mem) begin
                        illegal_nxt = illegal_nxt || !is_long;
                        unique case (req.cls)
                            bit_flip, bit_set_op: cost_nxt = req.static_bit ?
                                mk(12, 2, 0) : mk(8, 1, 0);
                            bit_clear: cost_nxt = req.static_bit ? mk(14, 2, 0) : mk(10, 1, 0);
                            default: cost_nxt = req.static_bit ? mk(10, 2, 0) : mk(6, 1, 0);
                        endcase
                    end else begin
                        illegal_nxt = illegal_nxt || req.size != sz_byte;
                        unique case (req.cls)
                            bit_flip, bit_set_op: cost_nxt = req.static_bit ?
                                mk(12, 2, 1) : mk(8, 1, 1);
                            bit_clear: cost_nxt = req.static_bit ? mk(14, 2, 1) : mk(10, 1, 1);
                            default: cost_nxt = req.static_bit ? mk(8, 2, 0) : mk(4, 1, 0);
                        endcase
                        cost_nxt = add(cost_nxt, req.ea_cost);
                    end
                end
            endcase
        end
    end

    // Registered answer, one cycle after the request
    always_ff @(posedge mclk) begin
        if (srst) begin
            resp_valid_r <= 1'b0;
        end else begin
            resp_valid_r <= req_valid;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            resp_cost_r <= '0;
            resp_illegal_r <= 1'b0;
        end else if (req_valid) begin
            resp_cost_r <= cost_nxt;
            resp_illegal_r <= illegal_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    chk_resp_one_cycle: assert property (req_valid |=> resp_valid_r)
        else $error("answer not one cycle after request");
    chk_clear_dreg: assert property (req_valid && !req.looped && req.cls == clear_operand &&
        req.mode == data_reg_direct |=> resp_cost_r ==
        ($past(req.size) == sz_long ? mk(6, 1, 0) : mk(4, 1, 0)))
        else $error("clear on data register cost wrong");
    chk_indexed_clear: assert property (req_valid && !req.looped && req.cls == clear_operand &&
        req.size == sz_word && req.mode == ea_indexed |=> resp_cost_r == mk(16, 2, 1))
        else $error("indexed clear depends on index width");
    chk_ea_added: assert property (req_valid && !req.looped && req.cls == bit_test &&
        !req.static_bit && req.mode == ea_abs_l |=>
        resp_cost_r == add(mk(4, 1, 0), $past(req.ea_cost)))
        else $error("address cost not added");
    chk_nonfetch_ea: assert property (req_valid && !req.looped && req.cls == cond_set &&
        req.mode == ea_ind |=> resp_cost_r == add(mk(8, 1, 1), $past(req.ea_nf_cost)))
        else $error("nonfetching address cost not used");
    chk_loop_clear: assert property (req_valid && req.looped && req.cls == clear_operand &&
        req.size == sz_byte && req.mode == ea_ind |=> resp_cost_r ==
        ($past(req.outcome) == loop_continue ? mk(10, 0, 1) :
         $past(req.outcome) == loop_cc_true ? mk(18, 2, 1) : mk(16, 2, 1)))
        else $error("loop clear cost wrong");
    chk_shift_reg: assert property (req_valid && !req.looped && req.cls == logical_shift &&
        req.mode == data_reg_direct && req.size == sz_long |=>
        resp_cost_r.clocks == `CLK_W'(8 + 2 * int'($past(req.count))) &&
        resp_cost_r.reads == 1 && resp_cost_r.writes == 0)
        else $error("register shift cost wrong");
    chk_shift_mem: assert property (req_valid && !req.looped && req.cls == rotate_plain &&
        req.mode == ea_postinc && req.size == sz_long |=> resp_illegal_r)
        else $error("long memory shift accepted");
    chk_loop_shift: assert property (req_valid && req.looped && req.cls == arith_shift &&
        req.size == sz_word && req.mode == ea_predec && req.outcome == loop_expired |=>
        resp_cost_r == mk(24, 3, 1) && !resp_illegal_r)
        else $error("loop shift cost wrong");
    chk_bit_dyn_reg: assert property (req_valid && !req.looped && req.cls == bit_clear &&
        !req.static_bit && req.mode == data_reg_direct && req.size == sz_long |=>
        resp_cost_r == mk(10, 1, 0))
        else $error("dynamic bit clear on register wrong");
    chk_bit_static: assert property (req_valid && !req.looped && req.cls == bit_test &&
        req.static_bit && req.mode == data_reg_direct && req.size == sz_long |=>
        resp_cost_r == mk(10, 2, 0))
        else $error("static bit test on register wrong");
    chk_bit_dyn_mem: assert property (req_valid && !req.looped && req.cls == bit_flip &&
        !req.static_bit && req.mode == ea_ind && req.size == sz_byte |=>
        resp_cost_r == add(mk(8, 1, 1), $past(req.ea_cost)))
        else $error("dynamic bit flip on memory wrong");

    cov_loop_true: cover property (req_valid && req.looped && req.outcome == loop_cc_true);
    cov_shift_reg: cover property (req_valid && req.cls == arith_shift && req.count != 0);
    cov_static_mem: cover property (req_valid && req.static_bit && req.mode == ea_disp16);
    cov_illegal: cover property (resp_valid_r && resp_illegal_r);

endmodule

//--- test_op_timing.sv
`timescale 1ns/1ps
`include "op_timing_params.svh"
module test_op_timing
    import op_timing_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    op_req_t req = '0;
    logic resp_valid_r;
    cost_t resp_cost_r;
    logic resp_illegal_r;
    int bad_count = 0;
    int samples_checked = 0;

    op_timing i_op_timing (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req(req),
        .resp_valid_r(resp_valid_r), .resp_cost_r(resp_cost_r),
        .resp_illegal_r(resp_illegal_r));

    initial begin
        forever #20 mclk = ~mclk;
    end

    function automatic cost_t cst(input int c, input int r, input int w);
        cost_t v;
        v.clocks = c[`CLK_W-1:0];
        v.reads = r[`RW_W-1:0];
        v.writes = w[`RW_W-1:0];
        return v;
    endfunction

    function automatic op_req_t mk(input op_class_t c, input op_size_t s, input ea_mode_t m);
        op_req_t v;
        v = '0;
        v.cls = c;
        v.size = s;
        v.mode = m;
        return v;
    endfunction

    task automatic cmp_cost(input string what, input cost_t exp, input cost_t got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %0d(%0d/%0d) seen %0d(%0d/%0d)", what, exp.clocks,
                exp.reads, exp.writes, got.clocks, got.reads, got.writes);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    // One request, answer judged one cycle later
    task automatic do_op(input string what, input op_req_t r, input int c, input int rd,
        input int wr, input logic ill);
        @(negedge mclk);
        cmp_bit({what, " idle"}, 1'b0, resp_valid_r);
        req = r;
        req_valid = 1'b1;
        @(negedge mclk);
        req_valid = 1'b0;
        cmp_bit({what, " valid"}, 1'b1, resp_valid_r);
        cmp_bit({what, " illegal"}, ill, resp_illegal_r);
        if (!ill) cmp_cost(what, cst(c, rd, wr), resp_cost_r);
    endtask

    task automatic t_clear_reg();
        for (int s = 0; s < 3; s++) begin
            do_op("clear reg", mk(clear_operand, op_size_t'(s), data_reg_direct),
                (s == 2) ? 6 : 4, 1, 0, 1'b0);
        end
    endtask

    task automatic t_ea_plus();
        op_req_t r;
        r = mk(twos_complement_op, sz_long, ea_disp16);
        r.ea_cost = cst(6, 2, 0);
        r.ea_nf_cost = cst(40, 7, 7);
        do_op("negate long mem", r, 18, 3, 2, 1'b0);
        for (int i = 0; i < 2; i++) begin
            r = mk(twos_complement_op, sz_word, ea_indexed);
            r.index_long = i[0];
            r.ea_cost = cst(10, 2, 0);
            r.ea_nf_cost = cst(30, 5, 5);
            do_op("negate indexed", r, 18, 3, 1, 1'b0);
            r.cls = clear_operand;
            do_op("clear indexed", r, 16, 2, 1, 1'b0);
        end
        r = mk(test_operand, sz_long, ea_abs_l);
        r.ea_cost = cst(12, 3, 0);
        do_op("test mem", r, 16, 4, 0, 1'b0);
        r = mk(cond_set, sz_byte, ea_ind);
        r.ea_cost = cst(30, 5, 5);
        r.ea_nf_cost = cst(4, 1, 0);
        do_op("cond set mem", r, 12, 2, 1, 1'b0);
        r.cls = locked_test_set;
        do_op("test and set mem", r, 18, 3, 1, 1'b0);
    endtask

    task automatic t_loop();
        int lc[3] = '{10, 18, 16};
        int tc[3] = '{18, 24, 20};
        op_req_t r;
        for (int k = 0; k < 3; k++) begin
            r = mk(clear_operand, sz_byte, ea_ind);
            r.looped = 1'b1;
            r.outcome = loop_out_t'(k);
            r.ea_cost = cst(8, 2, 0);
            do_op("loop clear", r, lc[k], (k == 0) ? 0 : 2, 1, 1'b0);
            r = mk(test_operand, sz_long, ea_postinc);
            r.looped = 1'b1;
            r.outcome = loop_out_t'(k);
            do_op("loop test", r, tc[k], (k == 0) ? 2 : 4, 0, 1'b0);
        end
    endtask

    task automatic t_shift();
        int sc[3] = '{18, 24, 22};
        op_req_t r;
        for (int i = 0; i < 4; i++) begin
            r = mk(op_class_t'(8 + i), sz_word, data_reg_direct);
            r.count = 6'h3F;
            do_op("shift reg word", r, 132, 1, 0, 1'b0);
            r.size = sz_long;
            r.count = 6'h05;
            do_op("shift reg long", r, 18, 1, 0, 1'b0);
            r.size = sz_byte;
            r.count = 6'h00;
            do_op("shift reg byte", r, 6, 1, 0, 1'b0);
            r = mk(op_class_t'(8 + i), sz_word, ea_postinc);
            r.ea_cost = cst(4, 1, 0);
            do_op("shift mem word", r, 12, 2, 1, 1'b0);
            r.size = sz_long;
            do_op("shift mem long", r, 0, 0, 0, 1'b1);
            for (int k = 0; k < 6; k++) begin
                r = mk(op_class_t'(8 + i), sz_word, (k < 3) ? ea_ind : ea_predec);
                r.looped = 1'b1;
                r.outcome = loop_out_t'(k % 3);
                do_op("loop shift", r, sc[k % 3] + ((k < 3) ? 0 : 2),
                    (k % 3 == 0) ? 1 : 3, 1, 1'b0);
            end
        end
    endtask

    task automatic t_bits();
        int dc[4] = '{8, 10, 8, 6};
        int mc[4] = '{8, 10, 8, 4};
        int xc[4] = '{12, 14, 12, 10};
        int yc[4] = '{12, 14, 12, 8};
        op_req_t r;
        for (int i = 0; i < 4; i++) begin
            r = mk(op_class_t'(12 + i), sz_long, data_reg_direct);
            do_op("bit reg dyn", r, dc[i], 1, 0, 1'b0);
            r.static_bit = 1'b1;
            do_op("bit reg static", r, xc[i], 2, 0, 1'b0);
            r.size = sz_byte;
            do_op("bit reg byte", r, 0, 0, 0, 1'b1);
            r = mk(op_class_t'(12 + i), sz_byte,
                (i == 0) ? ea_ind : ((i == 3) ? ea_abs_l : ea_disp16));
            r.ea_cost = cst(2, 1, 0);
            do_op("bit mem dyn", r, mc[i] + 2, 2, (i == 3) ? 0 : 1, 1'b0);
            r.static_bit = 1'b1;
            do_op("bit mem static", r, yc[i] + 2, 3, (i == 3) ? 0 : 1, 1'b0);
        end
    endtask

    task automatic t_clear_mem();
        int bc[7] = '{8, 8, 10, 12, 16, 12, 16};
        int br[7] = '{1, 1, 1, 2, 2, 2, 3};
        int lc[7] = '{12, 12, 14, 16, 20, 16, 20};
        op_req_t r;
        for (int m = 0; m < 7; m++) begin
            r = mk(clear_operand, sz_byte, ea_mode_t'(m + 2));
            r.ea_cost = cst(40, 7, 7);
            do_op("clear mem", r, bc[m], br[m], 1, 1'b0);
            r.size = sz_long;
            do_op("clear mem long", r, lc[m], br[m], 2, 1'b0);
        end
    endtask

    task automatic t_single();
        op_req_t r;
        r = mk(decimal_negate, sz_byte, data_reg_direct);
        do_op("decimal reg", r, 6, 1, 0, 1'b0);
        r.size = sz_word;
        do_op("decimal word", r, 0, 0, 0, 1'b1);
        r = mk(complement_with_extend, sz_word, data_reg_direct);
        do_op("extend complement reg", r, 4, 1, 0, 1'b0);
        r = mk(cond_set, sz_byte, data_reg_direct);
        do_op("cond set reg", r, 4, 1, 0, 1'b0);
        r.cls = locked_test_set;
        do_op("locked set reg", r, 4, 1, 0, 1'b0);
        r = mk(cond_set, sz_word, ea_ind);
        do_op("cond set word", r, 0, 0, 0, 1'b1);
        r = mk(decimal_negate, sz_byte, ea_predec);
        r.ea_cost = cst(6, 1, 0);
        r.ea_nf_cost = cst(40, 7, 7);
        do_op("decimal mem", r, 14, 2, 1, 1'b0);
        r.cls = ones_complement;
        r.size = sz_long;
        r.mode = ea_abs_w;
        do_op("ones complement long mem", r, 18, 2, 2, 1'b0);
    endtask

    task automatic t_loop_more();
        int cc[3] = '{12, 20, 18};
        int lc[3] = '{16, 24, 22};
        int nc[3] = '{18, 24, 22};
        int oc[3] = '{24, 30, 28};
        int tc[3] = '{14, 20, 18};
        op_req_t r;
        for (int k = 0; k < 3; k++) begin
            r = mk(clear_operand, sz_word, ea_predec);
            r.looped = 1'b1;
            r.outcome = loop_out_t'(k);
            do_op("loop clear pre", r, cc[k], (k == 0) ? 0 : 2, (k == 1) ? 0 : 1, 1'b0);
            r.size = sz_long;
            do_op("loop clear long pre", r, lc[k], (k == 0) ? 0 : 2, 2, 1'b0);
            r.cls = twos_complement_op;
            r.size = sz_byte;
            do_op("loop negate pre", r, nc[k], (k == 0) ? 2 : 3, (k == 0) ? 2 : 1, 1'b0);
            r.cls = test_operand;
            r.size = sz_word;
            do_op("loop test pre", r, tc[k], (k == 0) ? 1 : 3, 0, 1'b0);
            r.cls = decimal_negate;
            r.size = sz_byte;
            r.mode = ea_postinc;
            do_op("loop decimal", r, nc[k], (k == 0) ? 1 : 3, 1, 1'b0);
            r.cls = ones_complement;
            r.size = sz_long;
            r.mode = ea_ind;
            do_op("loop ones long", r, oc[k], (k == 0) ? 2 : 4, 2, 1'b0);
        end
        r = mk(decimal_negate, sz_word, ea_ind);
        r.looped = 1'b1;
        do_op("loop decimal word", r, 0, 0, 0, 1'b1);
        r.cls = bit_test;
        r.size = sz_byte;
        do_op("loop bit op", r, 0, 0, 0, 1'b1);
        r.cls = locked_test_set;
        do_op("loop locked set", r, 0, 0, 0, 1'b1);
        r.cls = arith_shift;
        r.size = sz_long;
        do_op("loop shift long", r, 0, 0, 0, 1'b1);
        r = mk(test_operand, sz_word, data_reg_direct);
        r.looped = 1'b1;
        do_op("loop register", r, 0, 0, 0, 1'b1);
    endtask

    task automatic t_illegal_reset();
        op_req_t r;
        r = mk(clear_operand, sz_word, ea_disp16);
        r.looped = 1'b1;
        do_op("loop disp", r, 0, 0, 0, 1'b1);
        do_op("addr reg", mk(clear_operand, sz_word, addr_reg_direct), 0, 0, 0, 1'b1);
        @(negedge mclk);
        srst = 1'b1;
        @(negedge mclk);
        srst = 1'b0;
        cmp_cost("cost after reset", '0, resp_cost_r);
        cmp_bit("illegal after reset", 1'b0, resp_illegal_r);
    endtask

    task automatic t_back_to_back();
        @(negedge mclk);
        req = mk(clear_operand, sz_long, data_reg_direct);
        req_valid = 1'b1;
        @(negedge mclk);
        req = mk(bit_clear, sz_long, data_reg_direct);
        cmp_cost("first of pair", cst(6, 1, 0), resp_cost_r);
        @(negedge mclk);
        req_valid = 1'b0;
        cmp_bit("second valid", 1'b1, resp_valid_r);
        cmp_cost("second of pair", cst(10, 1, 0), resp_cost_r);
    endtask

    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #(40 * 3000);
        bad_count++;
        finish_test();
    end

    initial begin
        repeat (12) @(negedge mclk);
        srst = 1'b0;
        t_clear_reg();
        t_ea_plus();
        t_loop();
        t_shift();
        t_bits();
        t_clear_mem();
        t_single();
        t_loop_more();
        t_illegal_reset();
        t_back_to_back();
        finish_test();
    end
endmodule
